// >>> logic/bbsc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbsc_defines.svh"

module bbsc_core (
  // Clock and cold reset (loss of both supplies)
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // System reset request, one cycle, same clock
  input  wire logic                          sys_reset_req,
  // Pins from outside the clock domain
  input  wire logic                          ref_clk_in,
  input  wire logic                          wake_pin_n,
  input  wire logic                          battery_below_threshold,
  // Control bits
  input  wire bbsc_pkg::bbsc_ctrl_t          ctrl,
  input  wire logic                          sleep_request,
  // Value writes
  input  wire logic                          load_we,
  input  wire logic [`BBSC_WORD_W-1:0]       load_wdata,
  input  wire logic                          cmp0_we,
  input  wire logic                          cmp1_we,
  input  wire logic [`BBSC_WORD_W-1:0]       cmp_wdata,
  input  wire logic                          trim_we,
  input  wire logic [`BBSC_DIV_W-1:0]        trim_wdata,
  // Event mask and clear
  input  wire logic                          mask_we,
  input  wire bbsc_pkg::bbsc_evt_t           mask_wdata,
  input  wire logic                          clear_we,
  input  wire bbsc_pkg::bbsc_evt_t           clear_wdata,
  // Retained storage
  input  wire logic                          mem_we,
  input  wire logic [`BBSC_MEM_AW-1:0]       mem_addr,
  input  wire logic [`BBSC_WORD_W-1:0]       mem_wdata,
  output logic [`BBSC_WORD_W-1:0]            mem_rdata,
  // Readback
  output logic [`BBSC_WORD_W-1:0]            seconds_count,
  output logic [`BBSC_WORD_W-1:0]            compare_value_0,
  output logic [`BBSC_WORD_W-1:0]            compare_value_1,
  output logic [`BBSC_WORD_W-1:0]            counter_load_value,
  output logic [`BBSC_DIV_W-1:0]             predivider_trim,
  output bbsc_pkg::bbsc_evt_t                event_mask,
  output bbsc_pkg::bbsc_evt_t                raw_event_status,
  output bbsc_pkg::bbsc_evt_t                masked_event_status,
  // Interrupt and power control
  output logic                               irq,
  output logic                               hibernating,
  output logic                               power_off_request_n_o,
  output logic                               power_off_request_n_oe_n
);

  import bbsc_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic ref_s1_ff;
  logic ref_s2_ff;
  logic ref_d_ff;
  logic wake_s1_ff;
  logic wake_s2_ff;
  logic wake_d_ff;
  logic bat_s1_ff;
  logic bat_s2_ff;

  // The first stage feeds only the second; edges are taken from stage two.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_s1_ff  <= 1'b0;
      ref_s2_ff  <= 1'b0;
      ref_d_ff   <= 1'b0;
      wake_s1_ff <= 1'b1;
      wake_s2_ff <= 1'b1;
      wake_d_ff  <= 1'b1;
      bat_s1_ff  <= 1'b0;
      bat_s2_ff  <= 1'b0;
    end else begin
      ref_s1_ff  <= ref_clk_in;
      ref_s2_ff  <= ref_s1_ff;
      ref_d_ff   <= ref_s2_ff;
      wake_s1_ff <= wake_pin_n;
      wake_s2_ff <= wake_s1_ff;
      wake_d_ff  <= wake_s2_ff;
      bat_s1_ff  <= battery_below_threshold;
      bat_s2_ff  <= bat_s1_ff;
    end
  end

  logic ref_tick;
  logic wake_fall;

  assign ref_tick  = ref_s2_ff & ~ref_d_ff;
  assign wake_fall = ~wake_s2_ff & wake_d_ff;

  // ---------------------------------------------------------------------------
  // Module-level clear
  // ---------------------------------------------------------------------------
  logic soft_clr;

  assign soft_clr = sys_reset_req & ~ctrl.seconds_counter_enable & ~ctrl.wake_pin_enable;

  // ---------------------------------------------------------------------------
  // Predivider and seconds counter
  // ---------------------------------------------------------------------------
  logic                      sec_pulse;
  logic [`BBSC_WORD_W-1:0]   cnt_ff;
  logic [`BBSC_WORD_W-1:0]   load_ff;
  logic [`BBSC_DIV_W-1:0]    trim_ff;

  bbsc_prediv u_prediv (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .soft_clr  (soft_clr),
    .run       (ctrl.seconds_counter_enable),
    .ref_tick  (ref_tick),
    .trim      (trim_ff),
    .sec_pulse (sec_pulse)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= `BBSC_CNT_RST;
    end else if (soft_clr) begin
      cnt_ff <= `BBSC_CNT_RST;
    end else if (load_we) begin
      cnt_ff <= load_wdata;
    end else if (sec_pulse && ctrl.seconds_counter_enable) begin
      cnt_ff <= cnt_ff + `BBSC_CNT_STEP;
    end
  end

  assign seconds_count = cnt_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      load_ff <= `BBSC_LOAD_RST;
      trim_ff <= `BBSC_TRIM_RST;
    end else if (soft_clr) begin
      load_ff <= `BBSC_LOAD_RST;
      trim_ff <= `BBSC_TRIM_RST;
    end else begin
      if (load_we) begin
        load_ff <= load_wdata;
      end
      if (trim_we) begin
        trim_ff <= trim_wdata;
      end
    end
  end

  assign counter_load_value = load_ff;
  assign predivider_trim    = trim_ff;

  // ---------------------------------------------------------------------------
  // Compare values and match detection
  // ---------------------------------------------------------------------------
  logic [`BBSC_WORD_W-1:0] cmp_ff [2];
  logic [1:0]              eq_now;
  logic [1:0]              eq_d_ff;
  logic [1:0]              match_hit;
  logic [1:0]              cmp_we;

  assign cmp_we = {cmp1_we, cmp0_we};

  for (genvar gi = 0; gi < 2; gi++) begin : g_cmp
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cmp_ff[gi] <= `BBSC_CMP_RST;
      end else if (soft_clr) begin
        cmp_ff[gi] <= `BBSC_CMP_RST;
      end else if (cmp_we[gi]) begin
        cmp_ff[gi] <= cmp_wdata;
      end
    end

    assign eq_now[gi] = (cnt_ff == cmp_ff[gi]);

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        eq_d_ff[gi] <= 1'b1;
      end else if (soft_clr) begin
        eq_d_ff[gi] <= 1'b1;
      end else begin
        eq_d_ff[gi] <= eq_now[gi];
      end
    end

    assign match_hit[gi] = eq_now[gi] & ~eq_d_ff[gi];
  end

  assign compare_value_0 = cmp_ff[0];
  assign compare_value_1 = cmp_ff[1];

  // ---------------------------------------------------------------------------
  // Hibernation sequence
  // ---------------------------------------------------------------------------
  bbsc_state_t state_ff;
  bbsc_state_t nxt_state;
  logic        bat_low_seen;
  logic        sleep_refused;
  logic        wake_by_pin;
  logic        wake_by_match;

  assign bat_low_seen  = ctrl.battery_low_detect_enable & bat_s2_ff
                       & (state_ff == bbsc_st_active);
  assign sleep_refused = bat_low_seen & ctrl.abort_on_battery_low;
  assign wake_by_pin   = ctrl.wake_pin_enable & ~wake_s2_ff;
  assign wake_by_match = ctrl.match_wake_enable & (|match_hit);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bbsc_st_active: begin
        if (sleep_request && !sleep_refused) begin
          nxt_state = bbsc_st_hib;
        end
      end
      bbsc_st_hib: begin
        if (wake_by_pin || wake_by_match) begin
          nxt_state = bbsc_st_active;
        end
      end
      default: begin
        nxt_state = bbsc_st_active;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= bbsc_st_active;
    end else if (soft_clr) begin
      state_ff <= bbsc_st_active;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hibernating              = (state_ff == bbsc_st_hib);
  assign power_off_request_n_o    = 1'b0;
  assign power_off_request_n_oe_n = ~hibernating;

  // ---------------------------------------------------------------------------
  // Events, mask and status
  // ---------------------------------------------------------------------------
  bbsc_evt_t raw_ff;
  bbsc_evt_t mask_ff;
  bbsc_evt_t masked_ff;
  bbsc_evt_t evt_set;
  bbsc_evt_t nxt_raw;
  bbsc_evt_t nxt_mask;

  always_comb begin
    evt_set                  = '0;
    evt_set.match0           = match_hit[0];
    evt_set.match1           = match_hit[1];
    evt_set.battery_low_flag = bat_low_seen;
    evt_set.ext_wake         = wake_fall;
  end

  assign nxt_raw  = evt_set | (raw_ff & ~(clear_we ? clear_wdata : bbsc_evt_t'('0)));
  assign nxt_mask = mask_we ? mask_wdata : mask_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      raw_ff    <= `BBSC_EVT_RST;
      mask_ff   <= `BBSC_EVT_RST;
      masked_ff <= `BBSC_EVT_RST;
    end else if (soft_clr) begin
      raw_ff    <= `BBSC_EVT_RST;
      mask_ff   <= `BBSC_EVT_RST;
      masked_ff <= `BBSC_EVT_RST;
    end else begin
      raw_ff    <= nxt_raw;
      mask_ff   <= nxt_mask;
      masked_ff <= nxt_raw & nxt_mask;
    end
  end

  assign raw_event_status    = raw_ff;
  assign event_mask          = mask_ff;
  assign masked_event_status = masked_ff;
  assign irq = |masked_ff;

  // ---------------------------------------------------------------------------
  // Retained storage
  // ---------------------------------------------------------------------------
  // The array has no reset so its contents outlive every reset but a cold one,
  // which in silicon loses them anyway; simulation shows X until written.
  logic [`BBSC_WORD_W-1:0] mem [`BBSC_MEM_WORDS];
  logic [`BBSC_WORD_W-1:0] mem_rdata_ff;

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rdata_ff <= '0;
    end else begin
      mem_rdata_ff <= mem[mem_addr];
    end
  end

  assign mem_rdata = mem_rdata_ff;

endmodule

`default_nettype wire

// >>> logic/bbsc_defines.svh
`ifndef BBSC_DEFINES_SVH
`define BBSC_DEFINES_SVH

// -----------------------------------------------------------------------------
// Widths and sizes
// -----------------------------------------------------------------------------
`define BBSC_WORD_W      32
`define BBSC_DIV_W       16
`define BBSC_SEC_IDX_W   6
`define BBSC_MEM_WORDS   64
`define BBSC_MEM_AW      6
`define BBSC_EVT_W       4

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define BBSC_CNT_RST     32'h0000_0000
`define BBSC_CMP_RST     32'hFFFF_FFFF
`define BBSC_LOAD_RST    32'hFFFF_FFFF
`define BBSC_TRIM_RST    16'h7FFF
`define BBSC_EVT_RST     4'h0

// -----------------------------------------------------------------------------
// Predivider timing
// -----------------------------------------------------------------------------
`define BBSC_NOM_DIV     16'h7FFF
`define BBSC_DIV_ZERO    16'h0000
`define BBSC_DIV_STEP    16'h0001
`define BBSC_TRIM_SLOT   6'h3F
`define BBSC_SEC_STEP    6'h01
`define BBSC_CNT_STEP    32'h0000_0001

`endif

// >>> logic/bbsc_pkg.sv
`include "bbsc_defines.svh"

package bbsc_pkg;

  // Control bits that software sets; they travel together into the core.
  typedef struct packed {
    logic seconds_counter_enable;
    logic wake_pin_enable;
    logic match_wake_enable;
    logic battery_low_detect_enable;
    logic abort_on_battery_low;
  } bbsc_ctrl_t;

  // Event vector, low bit first: match 0, match 1, battery low, wake pin.
  typedef struct packed {
    logic ext_wake;
    logic battery_low_flag;
    logic match1;
    logic match0;
  } bbsc_evt_t;

  typedef enum logic [1:0] {
    bbsc_st_active = 2'b01,
    bbsc_st_hib    = 2'b10
  } bbsc_state_t;

endpackage

// >>> logic/bbsc_prediv.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbsc_defines.svh"

module bbsc_prediv (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  input  wire logic                       soft_clr,
  // Reference and control
  input  wire logic                       run,
  input  wire logic                       ref_tick,
  input  wire logic [`BBSC_DIV_W-1:0]     trim,
  // One-second enable
  output logic                            sec_pulse
);

  logic [`BBSC_DIV_W-1:0]     cnt_ff;
  logic [`BBSC_SEC_IDX_W-1:0] sec_idx_ff;
  logic                       sec_pulse_ff;
  logic [`BBSC_SEC_IDX_W-1:0] nxt_sec_idx;
  logic [`BBSC_DIV_W-1:0]     nxt_reload;

  assign nxt_sec_idx = sec_idx_ff + `BBSC_SEC_STEP;
  assign nxt_reload  = (nxt_sec_idx == `BBSC_TRIM_SLOT) ? trim : `BBSC_NOM_DIV;
  assign sec_pulse   = sec_pulse_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff       <= `BBSC_NOM_DIV;
      sec_idx_ff   <= '0;
      sec_pulse_ff <= 1'b0;
    end else if (soft_clr) begin
      cnt_ff       <= `BBSC_NOM_DIV;
      sec_idx_ff   <= '0;
      sec_pulse_ff <= 1'b0;
    end else begin
      sec_pulse_ff <= 1'b0;
      if (run && ref_tick) begin
        if (cnt_ff == `BBSC_DIV_ZERO) begin
          cnt_ff       <= nxt_reload;
          sec_idx_ff   <= nxt_sec_idx;
          sec_pulse_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - `BBSC_DIV_STEP;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/bbsc_core_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbsc_defines.svh"

module bbsc_core_props (
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     arst_n,
  input wire logic                     sys_reset_req,
  // Requests and control
  input wire logic                     battery_below_threshold,
  input wire bbsc_pkg::bbsc_ctrl_t     ctrl,
  input wire logic                     sleep_request,
  input wire logic                     load_we,
  input wire logic [`BBSC_WORD_W-1:0]  load_wdata,
  // Readback
  input wire logic [`BBSC_WORD_W-1:0]  seconds_count,
  input wire logic [`BBSC_WORD_W-1:0]  compare_value_0,
  input wire logic [`BBSC_WORD_W-1:0]  counter_load_value,
  input wire bbsc_pkg::bbsc_evt_t      event_mask,
  input wire bbsc_pkg::bbsc_evt_t      raw_event_status,
  input wire bbsc_pkg::bbsc_evt_t      masked_event_status,
  // Interrupt and power
  input wire logic                     irq,
  input wire logic                     hibernating,
  input wire logic                     power_off_request_n_o,
  input wire logic                     power_off_request_n_oe_n
);
  import bbsc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_IRQ_OR: assert property (irq == (|masked_event_status))
    else $error("irq is not the OR of masked status");
  AST_PWR_PIN: assert property (power_off_request_n_oe_n == !hibernating
    && !power_off_request_n_o)
    else $error("power pin does not follow hibernation");
  AST_SLEEP: assert property (!hibernating && sleep_request
    && !(ctrl.battery_low_detect_enable && ctrl.abort_on_battery_low) |=> hibernating)
    else $error("sleep request not taken");
  AST_ABORT: assert property ((battery_below_threshold [*4]) ##0 (!hibernating
    && sleep_request && ctrl.battery_low_detect_enable && ctrl.abort_on_battery_low)
    |=> !hibernating)
    else $error("sleep taken with low battery and abort set");
  AST_BAT_OFF: assert property (!ctrl.battery_low_detect_enable
    && $past(ctrl.battery_low_detect_enable) == 1'b0
    |-> !$rose(raw_event_status.battery_low_flag))
    else $error("battery flag raised with detection off");
  AST_BAT_HIB: assert property ($past(hibernating)
    |-> !$rose(raw_event_status.battery_low_flag))
    else $error("battery flag raised in hibernation");
  AST_LOAD: assert property (load_we |=> seconds_count == $past(load_wdata)
    && counter_load_value == $past(load_wdata))
    else $error("load value not applied");
  AST_CNT_HOLD: assert property (!ctrl.seconds_counter_enable
    && $past(ctrl.seconds_counter_enable) == 1'b0 && !load_we && !sys_reset_req
    |=> $stable(seconds_count))
    else $error("counter moved while disabled");
  AST_CNT_STEP: assert property (!load_we && !sys_reset_req
    |=> seconds_count == $past(seconds_count)
    || seconds_count == $past(seconds_count) + 32'h0000_0001)
    else $error("counter stepped by more than one");
  AST_MATCH: assert property (seconds_count == compare_value_0
    && $past(seconds_count) != $past(compare_value_0) |=> raw_event_status.match0)
    else $error("match 0 not recorded");
  AST_MASKED: assert property ($stable(raw_event_status) && $stable(event_mask)
    |-> masked_event_status == (raw_event_status & event_mask))
    else $error("masked status is not raw and mask");
  AST_WAKE_MATCH: assert property ($rose(raw_event_status.match0) && $past(hibernating)
    && $past(ctrl.match_wake_enable) |-> !hibernating)
    else $error("match did not wake");
endmodule

bind bbsc_core bbsc_core_props bbsc_core_props_i (
  .mclk, .arst_n, .sys_reset_req, .battery_below_threshold, .ctrl, .sleep_request,
  .load_we, .load_wdata, .seconds_count, .compare_value_0, .counter_load_value,
  .event_mask, .raw_event_status, .masked_event_status, .irq, .hibernating,
  .power_off_request_n_o, .power_off_request_n_oe_n
);
`default_nettype wire

// >>> testbench/bbsc_regulator_model.sv
`timescale 1ns/1ps
`default_nettype none

module bbsc_regulator_model (
  // Power pin from the controller
  input  wire logic power_off_request_n_o,
  input  wire logic power_off_request_n_oe_n,
  // Resolved pin, regulator state and reference
  output logic      pin_level,
  output logic      power_good,
  output var logic  ref_clk
);
  // The pin has a pull-up, so a released pin reads high and the regulator runs.
  assign pin_level = power_off_request_n_oe_n ? 1'b1 : power_off_request_n_o;
  assign power_good = pin_level;
  // The reference oscillator runs free; half period of 32.768 kHz in ns.
  initial begin
    ref_clk = 1'b0;
    forever #15258.789 ref_clk = ~ref_clk;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_bbsc_core.sv
`timescale 1ns/1ps
`default_nettype none

module tb_bbsc_core;
  import bbsc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk, arst_n, sys_reset_req, ref_clk_in, wake_pin_n, battery_below_threshold;
  logic sleep_request, load_we, cmp0_we, cmp1_we, trim_we, mask_we, clear_we, mem_we;
  logic irq, hibernating, power_off_request_n_o, power_off_request_n_oe_n, pin_level, power_good;
  logic [31:0] load_wdata, cmp_wdata, mem_wdata, mem_rdata, seconds_count;
  logic [31:0] compare_value_0, compare_value_1, counter_load_value;
  logic [15:0] trim_wdata, predivider_trim;
  logic [5:0] mem_addr;
  bbsc_ctrl_t ctrl;
  bbsc_evt_t mask_wdata, clear_wdata, event_mask, raw_event_status, masked_event_status;
  int n_fail, checks, cyc;
  localparam int k_load = 0, k_cmp0 = 1, k_cmp1 = 2, k_trim = 3, k_mask = 4, k_clr = 5, k_mem = 6;

  bbsc_core bbsc_core_i (.*);
  bbsc_regulator_model bbsc_regulator_model_i (.power_off_request_n_o, .power_off_request_n_oe_n,
    .pin_level, .power_good, .ref_clk(ref_clk_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Every write is one cycle wide and is followed by an idle cycle, so that a
  // strobe never falls and rises again in one time step.
  task automatic wr(input int k, input logic [31:0] v);
    {load_wdata, cmp_wdata, mem_wdata} = {v, v, v};
    {trim_wdata, mask_wdata, clear_wdata} = {v[15:0], v[3:0], v[3:0]};
    {load_we, cmp0_we, cmp1_we, trim_we} = {k == k_load, k == k_cmp0, k == k_cmp1, k == k_trim};
    {mask_we, clear_we, mem_we} = {k == k_mask, k == k_clr, k == k_mem};
    tk(1);
    {load_we, cmp0_we, cmp1_we, trim_we, mask_we, clear_we, mem_we} = 7'h00;
    tk(1);
  endtask
  task automatic sleep;
    sleep_request = 1'b1;
    tk(1);
    sleep_request = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("count", 32'h0000_0000, seconds_count);
    chk("cmp0", 32'hFFFF_FFFF, compare_value_0);
    chk("cmp1", 32'hFFFF_FFFF, compare_value_1);
    chk("load", 32'hFFFF_FFFF, counter_load_value);
    chk("trim", 32'h0000_7FFF, {16'h0000, predivider_trim});
    chk("raw", 32'h0, {28'h0, raw_event_status});
    chk("mask", 32'h0, {28'h0, event_mask});
    chk("pin", 32'h1, {31'h0, pin_level});
  endtask
  task automatic t_writes;
    wr(k_load, 32'hA5A5_0001);
    wr(k_cmp0, 32'h0000_0010);
    wr(k_cmp1, 32'h0000_0020);
    wr(k_trim, 32'h0000_8000);
    tk(8);
    chk("count", 32'hA5A5_0001, seconds_count);
    chk("load", 32'hA5A5_0001, counter_load_value);
    chk("cmp0", 32'h0000_0010, compare_value_0);
    chk("cmp1", 32'h0000_0020, compare_value_1);
    chk("trim", 32'h0000_8000, {16'h0000, predivider_trim});
  endtask
  task automatic t_match;
    wr(k_mask, 32'h1);
    chk("mask", 32'h1, {28'h0, event_mask});
    wr(k_load, 32'h10);
    tk(2);
    chk("raw", 32'h1, {28'h0, raw_event_status});
    chk("irq", 32'h1, {31'h0, irq});
    wr(k_load, 32'h20);
    tk(2);
    chk("masked", 32'h1, {28'h0, masked_event_status});
    wr(k_clr, 32'h1);
    tk(2);
    chk("raw", 32'h2, {28'h0, raw_event_status});
    chk("irq", 32'h0, {31'h0, irq});
    wr(k_clr, 32'h2);
    tk(4);
    chk("raw", 32'h0, {28'h0, raw_event_status});
  endtask
  task automatic t_batt;
    battery_below_threshold = 1'b1;
    tk(8);
    chk("raw", 32'h0, {28'h0, raw_event_status});
    ctrl.battery_low_detect_enable = 1'b1;
    tk(4);
    chk("raw", 32'h4, {28'h0, raw_event_status});
    ctrl.abort_on_battery_low = 1'b1;
    sleep();
    tk(3);
    chk("hib", 32'h0, {31'h0, hibernating});
    battery_below_threshold = 1'b0;
    ctrl = 5'h00;
    tk(4);
    wr(k_clr, 32'h4);
    tk(2);
    chk("raw", 32'h0, {28'h0, raw_event_status});
  endtask
  task automatic t_storage;
    mem_addr = 6'h00;
    wr(k_mem, 32'h1357_9BDF);
    mem_addr = 6'h3F;
    wr(k_mem, 32'h2468_ACE0);
    mem_addr = 6'h00;
    tk(2);
    chk("mem0", 32'h1357_9BDF, mem_rdata);
  endtask
  task automatic t_match_wake;
    wr(k_cmp0, 32'h30);
    wr(k_load, 32'h2F);
    // wake source set before the request
    ctrl.match_wake_enable = 1'b1;
    sleep();
    tk(2);
    chk("hib", 32'h1, {31'h0, hibernating});
    chk("power", 32'h0, {31'h0, power_good});
    wr(k_load, 32'h30);
    tk(3);
    chk("hib", 32'h0, {31'h0, hibernating});
    chk("pin", 32'h1, {31'h0, pin_level});
    chk("raw", 32'h1, {28'h0, raw_event_status});
    wr(k_clr, 32'hF);
    tk(2);
  endtask
  task automatic t_pin_wake;
    // Wake pin enable only.
    ctrl = 5'h08;
    sleep();
    tk(2);
    ctrl.battery_low_detect_enable = 1'b1;
    battery_below_threshold = 1'b1;
    tk(10);
    chk("raw", 32'h0, {28'h0, raw_event_status});
    battery_below_threshold = 1'b0;
    ctrl.battery_low_detect_enable = 1'b0;
    tk(4);
    chk("hib", 32'h1, {31'h0, hibernating});
    wake_pin_n = 1'b0;
    tk(6);
    chk("hib", 32'h0, {31'h0, hibernating});
    chk("raw", 32'h8, {28'h0, raw_event_status});
    wake_pin_n = 1'b1;
    tk(4);
  endtask
  task automatic t_sysreset;
    sys_reset_req = 1'b1;
    tk(1);
    sys_reset_req = 1'b0;
    tk(2);
    chk("cmp0", 32'h30, compare_value_0);
    // Counter enable alone must also block the system reset.
    ctrl = 5'h10;
    sys_reset_req = 1'b1;
    tk(1);
    sys_reset_req = 1'b0;
    tk(2);
    chk("cmp0", 32'h30, compare_value_0);
    ctrl = 5'h00;
    tk(2);
    sys_reset_req = 1'b1;
    tk(1);
    sys_reset_req = 1'b0;
    mem_addr = 6'h3F;
    tk(2);
    chk("cmp0", 32'hFFFF_FFFF, compare_value_0);
    chk("raw", 32'h0, {28'h0, raw_event_status});
    chk("mem63", 32'h2468_ACE0, mem_rdata);
  endtask

  // ---------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // The sequence needs well under a thousand cycles; this leaves margin.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {arst_n, sys_reset_req, battery_below_threshold, sleep_request, wake_pin_n} = 5'h01;
    {load_we, cmp0_we, cmp1_we, trim_we, mask_we, clear_we, mem_we} = 7'h00;
    {load_wdata, cmp_wdata, mem_wdata, trim_wdata} = 112'h0;
    {mask_wdata, clear_wdata, ctrl, mem_addr} = 19'h0;
    tk(20);
    arst_n = 1'b1;
    tk(1);
    t_reset();
    t_writes();
    t_match();
    t_batt();
    t_storage();
    t_match_wake();
    t_pin_wake();
    t_sysreset();
    conclude();
  end
endmodule
`default_nettype wire
